// [hdl/bridge_cfg_pkg.sv]
// Behaviour
// - Programming interface byte always reads 00h
// - Class reads sub-class 04h, base 06h
// - Cache line size RW, reset 00h, unused
// - Both latency timers read 00h, writes ignored
// - Header type always reads 01h
// - Primary bus number RW byte, reset 00h
// - Secondary bus number RW byte, reset 00h
// - Subordinate bus number RW byte, reset 00h
// - I/O addressing capability nibbles read 1h
// - Base nibble gives window bottom bits 15:12
// - Limit nibble gives window top bits 15:12
// - Inclusive I/O window decides forwarding
// - Window bits 31:16 come from outside inputs
`default_nettype none

package bridge_cfg_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] OFF_CLASS   = 8'h08;
  localparam logic [7:0] OFF_HDR     = 8'h0c;
  localparam logic [7:0] OFF_BUSNUM  = 8'h18;
  localparam logic [7:0] OFF_IOWIN   = 8'h1c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PIF_LSB     = 8;
  localparam int SUBC_LSB    = 16;
  localparam int BASEC_LSB   = 24;
  localparam int CLS_LSB     = 0;
  localparam int PLAT_LSB    = 8;
  localparam int HDR_LSB     = 16;
  localparam int PBUS_LSB    = 0;
  localparam int SBUS_LSB    = 8;
  localparam int SUBB_LSB    = 16;
  localparam int SLAT_LSB    = 24;
  localparam int IOB_CAP_LSB = 0;
  localparam int IOB_LSB     = 4;
  localparam int IOL_CAP_LSB = 8;
  localparam int IOL_LSB     = 12;

  // ****************************************
  // Constant field values and resets
  // ****************************************
  localparam logic [7:0]  PROG_IF     = 8'h00;
  localparam logic [7:0]  SUB_CLASS   = 8'h04;
  localparam logic [7:0]  BASE_CLASS  = 8'h06;
  localparam logic [7:0]  LAT_TIMER   = 8'h00;
  localparam logic [7:0]  HDR_TYPE    = 8'h01;
  localparam logic [3:0]  IO_ADDR_CAP = 4'h1;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [3:0]  NIB_RST     = 4'h0;
  localparam logic [11:0] WIN_BOT_LOW = 12'h000;
  localparam logic [11:0] WIN_TOP_LOW = 12'hfff;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [15:0] upper_base;
    logic [15:0] upper_limit;
  } io_req_s;

endpackage

`default_nettype wire

// [hdl/bridge_config_header_regs.sv]
`default_nettype none

module bridge_config_header_regs (
  input  wire logic                      clk,             // 20 MHz core clock
  input  wire logic                      rst_n,           // Async reset, active low
  input  wire bridge_cfg_pkg::reg_req_s  reg_req,         // Register access request
  output var  logic [31:0]               rdata,           // Read data, cycle after read
  input  wire bridge_cfg_pkg::io_req_s   io_req,          // I/O address to classify
  output var  logic                      io_done,         // Classification pulse
  output var  logic                      io_forward,      // Address inside I/O window
  output var  logic [7:0]                primary_bus,     // Primary bus number
  output var  logic [7:0]                secondary_bus,   // Secondary bus number
  output var  logic [7:0]                subordinate_bus  // Subordinate bus number
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] window_edge(input logic [15:0] upper,
                                              input logic [3:0]  nib,
                                              input logic [11:0] low);
    window_edge = {upper, nib, low};
  endfunction

  // Whole-dword decode; a byte address inside a dword does not alias onto it
  function automatic logic hits(input logic [bridge_cfg_pkg::ADDR_W-1:0] addr,
                                input logic [bridge_cfg_pkg::ADDR_W-1:0] off);
    hits = (addr == off);
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] cache_line_size;
  logic [3:0] io_window_base;
  logic [3:0] io_window_limit;

  // ****************************************
  // Decode
  // ****************************************
  wire logic sel_class  = hits(reg_req.addr, bridge_cfg_pkg::OFF_CLASS);
  wire logic sel_hdr    = hits(reg_req.addr, bridge_cfg_pkg::OFF_HDR);
  wire logic sel_busnum = hits(reg_req.addr, bridge_cfg_pkg::OFF_BUSNUM);
  wire logic sel_iowin  = hits(reg_req.addr, bridge_cfg_pkg::OFF_IOWIN);

  wire logic wr_hdr     = reg_req.wr && sel_hdr;
  wire logic wr_busnum  = reg_req.wr && sel_busnum;
  wire logic wr_iowin   = reg_req.wr && sel_iowin;

  // ****************************************
  // Read images
  // ****************************************
  // Low byte of the class dword is the revision, outside this block: reads zero
  wire logic [31:0] img_class = {bridge_cfg_pkg::BASE_CLASS,
                                 bridge_cfg_pkg::SUB_CLASS,
                                 bridge_cfg_pkg::PROG_IF,
                                 8'h00};

  // Top byte of this dword belongs to other logic and reads zero
  wire logic [31:0] img_hdr   = {8'h00,
                                 bridge_cfg_pkg::HDR_TYPE,
                                 bridge_cfg_pkg::LAT_TIMER,
                                 cache_line_size};

  wire logic [31:0] img_bus   = {bridge_cfg_pkg::LAT_TIMER,
                                 subordinate_bus,
                                 secondary_bus,
                                 primary_bus};

  // Upper half is the secondary status, outside this block
  wire logic [31:0] img_iowin = {16'h0000,
                                 io_window_limit,
                                 bridge_cfg_pkg::IO_ADDR_CAP,
                                 io_window_base,
                                 bridge_cfg_pkg::IO_ADDR_CAP};

  // Unmapped offsets read zero
  wire logic [31:0] read_mux = sel_class  ? img_class :
                               sel_hdr    ? img_hdr   :
                               sel_busnum ? img_bus   :
                               sel_iowin  ? img_iowin : 32'h0000_0000;

  wire logic [31:0] next_rdata = reg_req.rd ? read_mux : 32'h0000_0000;

  // ****************************************
  // I/O window
  // ****************************************
  wire logic [31:0] win_bottom = window_edge(io_req.upper_base,
                                             io_window_base,
                                             bridge_cfg_pkg::WIN_BOT_LOW);
  wire logic [31:0] win_top    = window_edge(io_req.upper_limit,
                                             io_window_limit,
                                             bridge_cfg_pkg::WIN_TOP_LOW);

  // Inclusive at both ends; a top edge below the bottom edge yields no hit
  wire logic in_window = (io_req.addr >= win_bottom) &&
                         (io_req.addr <= win_top);

  // ****************************************
  // Read data
  // ****************************************
  // Data stand for one cycle only so a stale word is never mistaken for an answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // Cache line size
  // ****************************************
  // Held for software only; nothing in the block reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cache_line_size <= bridge_cfg_pkg::BYTE_RST;
    end else if (wr_hdr) begin
      cache_line_size <= reg_req.wdata[bridge_cfg_pkg::CLS_LSB +: 8];
    end
  end

  // ****************************************
  // Bus numbers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_bus     <= bridge_cfg_pkg::BYTE_RST;
      secondary_bus   <= bridge_cfg_pkg::BYTE_RST;
      subordinate_bus <= bridge_cfg_pkg::BYTE_RST;
    end else if (wr_busnum) begin
      primary_bus     <= reg_req.wdata[bridge_cfg_pkg::PBUS_LSB +: 8];
      secondary_bus   <= reg_req.wdata[bridge_cfg_pkg::SBUS_LSB +: 8];
      subordinate_bus <= reg_req.wdata[bridge_cfg_pkg::SUBB_LSB +: 8];
    end
  end

  // ****************************************
  // I/O base and limit nibbles
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_window_base  <= bridge_cfg_pkg::NIB_RST;
      io_window_limit <= bridge_cfg_pkg::NIB_RST;
    end else if (wr_iowin) begin
      io_window_base  <= reg_req.wdata[bridge_cfg_pkg::IOB_LSB +: 4];
      io_window_limit <= reg_req.wdata[bridge_cfg_pkg::IOL_LSB +: 4];
    end
  end

  // ****************************************
  // Forwarding decision
  // ****************************************
  // One cycle of latency keeps the comparator off the output path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_done    <= 1'b0;
      io_forward <= 1'b0;
    end else begin
      io_done    <= io_req.valid;
      io_forward <= io_req.valid && in_window;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_prog_if_zero: assert property (
    reg_req.rd && sel_class |=> rdata[bridge_cfg_pkg::PIF_LSB +: 8] == 8'h00)
    else $error("programming interface byte not zero");

  a_class_code: assert property (
    reg_req.rd && sel_class |=>
      rdata[bridge_cfg_pkg::SUBC_LSB +: 8] == 8'h04 &&
      rdata[bridge_cfg_pkg::BASEC_LSB +: 8] == 8'h06)
    else $error("class code wrong");

  a_cache_write: assert property (
    wr_hdr ##1 reg_req.rd && sel_hdr |=>
      rdata[bridge_cfg_pkg::CLS_LSB +: 8] == $past(reg_req.wdata[7:0], 2))
    else $error("cache line size lost its write");

  a_latency_zero: assert property (
    reg_req.rd && (sel_hdr || sel_busnum) |=>
      (rdata[bridge_cfg_pkg::PLAT_LSB +: 8] == 8'h00 || $past(sel_busnum)) &&
      (rdata[bridge_cfg_pkg::SLAT_LSB +: 8] == 8'h00 || $past(sel_hdr)))
    else $error("latency timer not zero");

  a_header_type: assert property (
    reg_req.rd && sel_hdr |=> rdata[bridge_cfg_pkg::HDR_LSB +: 8] == 8'h01)
    else $error("header type not one");

  a_primary_bus: assert property (
    wr_busnum |=> primary_bus == $past(reg_req.wdata[7:0]))
    else $error("primary bus number not stored");

  a_secondary_bus: assert property (
    wr_busnum ##1 reg_req.rd && sel_busnum |=>
      rdata[15:8] == $past(reg_req.wdata[15:8], 2))
    else $error("secondary bus number readback wrong");

  a_subord_hold: assert property (
    !wr_busnum |=> $stable(subordinate_bus))
    else $error("subordinate bus number changed without write");

  a_cap_nibbles: assert property (
    reg_req.rd && sel_iowin |=> rdata[3:0] == 4'h1 && rdata[11:8] == 4'h1)
    else $error("I/O addressing nibble not one");

  a_base_edge: assert property (
    io_req.valid && io_req.addr == {io_req.upper_base, io_window_base, 12'h000} &&
      io_window_base <= io_window_limit && io_req.upper_base <= io_req.upper_limit
      |=> io_done && io_forward)
    else $error("window bottom not forwarded");

  a_limit_edge: assert property (
    io_req.valid && io_req.addr == {io_req.upper_limit, io_window_limit, 12'hfff} &&
      io_window_base <= io_window_limit && io_req.upper_base <= io_req.upper_limit
      |=> io_done && io_forward ##1 io_done == $past(io_req.valid))
    else $error("window top not forwarded");

  a_fwd_outside: assert property (
    io_req.valid && io_req.addr[31:12] > {io_req.upper_limit, io_window_limit}
      |=> io_done && !io_forward)
    else $error("address above window forwarded");

  a_upper_half: assert property (
    io_req.valid && io_req.addr[31:16] < io_req.upper_base |=> !io_forward)
    else $error("upper address half ignored");

  a_ro_ignored: assert property (
    reg_req.wr && sel_class ##1 reg_req.rd && sel_class |=>
      rdata == 32'h0604_0000)
    else $error("write reached read-only class dword");

  a_rdata_quiet: assert property (
    !reg_req.rd |=> rdata == 32'h0000_0000 && $stable(io_window_base) || $past(wr_iowin))
    else $error("read data outside answer cycle");

  // ****************************************
  // Checks: state right after reset
  // ****************************************
  // No request can land before the first edge after release, so state is still at reset
  a_cache_reset: assert property (
    !$past(rst_n) |-> cache_line_size == 8'h00)
    else $error("cache line size not reset");

  a_pri_reset: assert property (
    !$past(rst_n) |-> primary_bus == 8'h00)
    else $error("primary bus number not reset");

  a_sec_reset: assert property (
    !$past(rst_n) |-> secondary_bus == 8'h00)
    else $error("secondary bus number not reset");

  a_sub_reset: assert property (
    !$past(rst_n) |-> subordinate_bus == 8'h00)
    else $error("subordinate bus number not reset");

  a_base_reset: assert property (
    !$past(rst_n) |-> io_window_base == 4'h0)
    else $error("I/O base nibble not reset");

  a_limit_reset: assert property (
    !$past(rst_n) |-> io_window_limit == 4'h0)
    else $error("I/O limit nibble not reset");

  // ****************************************
  // Checks: storage
  // ****************************************
  a_cache_store: assert property (
    wr_hdr |=> cache_line_size == $past(reg_req.wdata[7:0]))
    else $error("cache line size not stored");

  a_cache_hold: assert property (
    !wr_hdr |=> $stable(cache_line_size))
    else $error("cache line size changed without write");

  a_base_store: assert property (
    wr_iowin |=> io_window_base == $past(reg_req.wdata[7:4]))
    else $error("I/O base nibble not stored");

  a_limit_store: assert property (
    wr_iowin |=> io_window_limit == $past(reg_req.wdata[15:12]))
    else $error("I/O limit nibble not stored");

  a_window_hold: assert property (
    !wr_iowin |=> $stable(io_window_base) && $stable(io_window_limit))
    else $error("I/O window nibble changed without write");

  // ****************************************
  // Checks: read images
  // ****************************************
  a_class_whole: assert property (
    reg_req.rd && sel_class |=> rdata == 32'h0604_0000)
    else $error("class dword wrong");

  a_hdr_image: assert property (
    reg_req.rd && sel_hdr |=> rdata[31:24] == 8'h00 && rdata[7:0] == cache_line_size)
    else $error("header dword image wrong");

  a_bus_image: assert property (
    reg_req.rd && sel_busnum |=>
      rdata[23:0] == {subordinate_bus, secondary_bus, primary_bus})
    else $error("bus number dword image wrong");

  a_window_image: assert property (
    reg_req.rd && sel_iowin |=>
      rdata[31:16] == 16'h0000 && rdata[7:4] == io_window_base &&
      rdata[15:12] == io_window_limit)
    else $error("I/O window dword image wrong");

  a_unmapped_zero: assert property (
    reg_req.rd && !(sel_class || sel_hdr || sel_busnum || sel_iowin) |=>
      rdata == 32'h0000_0000)
    else $error("unmapped offset read not zero");

  // ****************************************
  // Checks: forwarding pulses
  // ****************************************
  a_done_follows: assert property (
    io_req.valid |=> io_done)
    else $error("classification not answered");

  a_idle_quiet: assert property (
    !io_req.valid |=> !io_done && !io_forward)
    else $error("classification pulse without request");

  a_inside_fwd: assert property (
    io_req.valid &&
      io_req.addr >= {io_req.upper_base, io_window_base, 12'h000} &&
      io_req.addr <= {io_req.upper_limit, io_window_limit, 12'hfff}
      |=> io_forward)
    else $error("address inside window not forwarded");

  a_fwd_below: assert property (
    io_req.valid && io_req.addr < {io_req.upper_base, io_window_base, 12'h000}
      |=> !io_forward)
    else $error("address below window forwarded");

endmodule // bridge_config_header_regs

`default_nettype wire

// [dv/cfg_requester.sv]
`default_nettype none

// ****************************************
// Upstream configuration requester model
// ****************************************
module cfg_requester (
  input  wire logic                     clk,        // Core clock
  input  wire logic [31:0]              rdata,      // Read data from the block
  input  wire logic                     io_done,    // Classification pulse
  input  wire logic                     io_forward, // Window hit
  output var  bridge_cfg_pkg::reg_req_s reg_req,    // Register request
  output var  bridge_cfg_pkg::io_req_s  io_req      // I/O address to classify
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_req = '0;
    io_req  = '0;
  end

  // Software programs bus numbers through plain dword writes
  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge clk);
    reg_req.wr    <= 1'b0;
    // Released data is scrambled so a stale bus value cannot pass for a write
    reg_req.wdata <= ~d;
  endtask

  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.rd   <= 1'b1;
    @(posedge clk);
    reg_req.rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Write then read with no idle cycle between the two strobes
  task automatic cfg_write_read(input logic [7:0] a, input logic [31:0] d,
                                output logic [31:0] q);
    @(posedge clk);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge clk);
    reg_req.wr    <= 1'b0;
    reg_req.wdata <= ~d;
    reg_req.rd    <= 1'b1;
    @(posedge clk);
    reg_req.rd    <= 1'b0;
    #1;
    q = rdata;
  endtask

  task automatic classify(input logic [31:0] a, input logic [15:0] ub, input logic [15:0] ul,
                          output logic done, output logic fwd);
    @(posedge clk);
    io_req <= '{valid: 1'b1, addr: a, upper_base: ub, upper_limit: ul};
    @(posedge clk);
    io_req.valid <= 1'b0;
    io_req.addr  <= ~a;
    #1;
    done = io_done;
    fwd  = io_forward;
  endtask
endmodule // cfg_requester

`default_nettype wire

// [dv/bridge_config_header_regs_tb.sv]
`default_nettype none

module bridge_config_header_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                     clk;
  logic                     rst_n;
  bridge_cfg_pkg::reg_req_s reg_req;
  bridge_cfg_pkg::io_req_s  io_req;
  logic [31:0]              rdata;
  logic                     io_done;
  logic                     io_forward;
  logic [7:0]               primary_bus;
  logic [7:0]               secondary_bus;
  logic [7:0]               subordinate_bus;
  int                       fails;
  int                       num_checks;
  int                       seed;
  logic [7:0]               cls;
  logic [23:0]              bus;
  logic [3:0]               bnib;
  logic [3:0]               lnib;
  logic [7:0]               addrs [6] = '{8'h08, 8'h0c, 8'h18, 8'h1c, 8'h20, 8'h04};

  bridge_config_header_regs u_bridge_config_header_regs (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .rdata(rdata), .io_req(io_req),
    .io_done(io_done), .io_forward(io_forward), .primary_bus(primary_bus),
    .secondary_bus(secondary_bus), .subordinate_bus(subordinate_bus));

  cfg_requester u_cfg_requester (
    .clk(clk), .rdata(rdata), .io_done(io_done), .io_forward(io_forward),
    .reg_req(reg_req), .io_req(io_req));

  // ****************************************
  // Expectations and checking
  // ****************************************
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h08:   return 32'h06040000;
      8'h0c:   return {8'h00, 8'h01, 8'h00, cls};
      8'h18:   return {8'h00, bus};
      8'h1c:   return {16'h0000, lnib, 4'h1, bnib, 4'h1};
      default: return 32'h00000000;
    endcase
  endfunction

  function automatic logic exp_fwd(input logic [31:0] a, input logic [15:0] ub,
                                   input logic [15:0] ul);
    return (a >= {ub, bnib, 12'h000}) && (a <= {ul, lnib, 12'hfff});
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic model_upd(input logic [7:0] a, input logic [31:0] d);
    if (a == 8'h0c) cls = d[7:0];
    if (a == 8'h18) bus = d[23:0];
    if (a == 8'h1c) begin
      bnib = d[7:4];
      lnib = d[15:12];
    end
  endtask

  task automatic wr_upd(input logic [7:0] a, input logic [31:0] d);
    u_cfg_requester.cfg_write(a, d);
    model_upd(a, d);
  endtask

  task automatic wr_rd_chk(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    u_cfg_requester.cfg_write_read(a, d, v);
    model_upd(a, d);
    check(v, exp_rd(a));
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] v;
    u_cfg_requester.cfg_read(a, v);
    check(v, exp_rd(a));
    check({8'h00, subordinate_bus, secondary_bus, primary_bus}, {8'h00, bus});
    @(posedge clk);
    #1;
    check(rdata, 32'h0000_0000);
  endtask

  task automatic io_chk(input logic [31:0] a, input logic [15:0] ub, input logic [15:0] ul);
    logic d;
    logic f;
    u_cfg_requester.classify(a, ub, ul, d, f);
    check(d, 1'b1);
    check(f, exp_fwd(a, ub, ul));
    @(posedge clk);
    #1;
    check({io_done, io_forward}, 2'h0);
  endtask

  task automatic do_reset(input int n);
    rst_n <= 1'b0;
    cls = 8'h00;
    bus = 24'h0;
    bnib = 4'h0;
    lnib = 4'h0;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hung run is cut short and counted as a mismatch
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] a;
    fails = 0;
    num_checks = 0;
    seed = 71925;
    do_reset(4);
    foreach (addrs[i]) rd_chk(addrs[i]);
    // Write strobe followed at once by a read strobe of the same dword
    wr_rd_chk(8'h0c, 32'h1234_56a7);
    wr_rd_chk(8'h18, 32'h5566_7788);
    wr_rd_chk(8'h08, 32'hffff_ffff);
    wr_rd_chk(8'h1c, 32'h0000_f0f0);
    // Ones everywhere, including read-only and unmapped places
    foreach (addrs[i]) wr_upd(addrs[i], 32'hffffffff);
    foreach (addrs[i]) rd_chk(addrs[i]);
    for (int i = 0; i < 40; i++) begin
      d = $random(seed);
      wr_upd(addrs[$unsigned($random(seed)) % 6], d);
      rd_chk(addrs[$unsigned($random(seed)) % 6]);
    end
    // Window edges: bottom, below bottom, top, above top
    wr_upd(8'h1c, 32'h00005030);
    io_chk(32'h00013000, 16'h0001, 16'h0001);
    io_chk(32'h00012fff, 16'h0001, 16'h0001);
    io_chk(32'h00015fff, 16'h0001, 16'h0001);
    io_chk(32'h00016000, 16'h0001, 16'h0001);
    io_chk(32'h0001f000, 16'h0001, 16'h0002);
    io_chk(32'h00003000, 16'h0001, 16'h0001);
    // Limit nibble below base nibble with equal upper halves does not forward
    wr_upd(8'h1c, 32'h00003050);
    io_chk(32'h00014000, 16'h0001, 16'h0001);
    for (int i = 0; i < 40; i++) begin
      wr_upd(8'h1c, $random(seed));
      a = {14'h0, 2'($random(seed)), 16'($random(seed))};
      io_chk(a, 16'h0001, 16'($unsigned($random(seed)) % 3));
    end
    // Reset in mid-run restores every writable field
    wr_upd(8'h18, 32'h00a5b6c7);
    do_reset(2);
    rd_chk(8'h18);
    rd_chk(8'h1c);
    rd_chk(8'h0c);
    report_and_stop();
  end
endmodule // bridge_config_header_regs_tb

`default_nettype wire
